// *** src/cts_supervision.sv ***
// Current transformer supervision: open secondary circuit alarm.
// Assumes measurements arrive on the same clock with a one-cycle
// strobe every 5 ms; settings of eight groups arrive as flat buses.
//
// How it works
// - No alarm while any phase above upper limit
// - Some phase must exceed lower limit
// - Some phase must be below lower limit
// - Min over max phase ratio below setting
// - Negative over positive sequence above setting
// - Optional phase plus residual sum above setting
// - Alarm after conditions hold for delay
// - Eight setting groups, one common selector
// - Block and group change while running
// - Millisecond stamped on/off events for outputs
// - Resettable alarm and block event counters
// - Residual source none, first or second
// - Residual monitoring switch independent of phases
// - Pre-fault is 20 ms mean before event
// - Release hysteresis 97 and 103 percent
// - Residual added or subtracted by polarity
// - Compensation command zeroes present residual
`timescale 1ns/100ps
`default_nettype none
`include "cts_defs.svh"
module cts_supervision
  import cts_pkg::*;
#(
  parameter int W     = 16,
  parameter int DLY_W = 16,
  parameter int CNT_W = 16,
  parameter int TS_W  = 32
) (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     reset_n,
  // Measurements
  input  wire logic                     meas_valid,
  input  wire logic [W-1:0]             phase_a_magnitude,
  input  wire logic [W-1:0]             phase_b_magnitude,
  input  wire logic [W-1:0]             phase_c_magnitude,
  input  wire logic [W-1:0]             residual_one_magnitude,
  input  wire logic [W-1:0]             residual_two_magnitude,
  input  wire logic [W-1:0]             positive_sequence_current,
  input  wire logic [W-1:0]             negative_sequence_current,
  input  wire logic [W-1:0]             phase_a_angle,
  input  wire logic [W-1:0]             phase_b_angle,
  input  wire logic [W-1:0]             phase_c_angle,
  input  wire logic [W-1:0]             residual_one_angle,
  input  wire logic [W-1:0]             residual_two_angle,
  // Setting groups
  input  wire logic [2:0]               group_select,
  input  wire logic [8*W-1:0]           phase_upper_threshold,
  input  wire logic [8*W-1:0]           phase_lower_threshold,
  input  wire logic [8*8-1:0]           min_max_ratio_threshold,
  input  wire logic [8*8-1:0]           neg_pos_sequence_ratio_threshold,
  input  wire logic [8*W-1:0]           summation_difference_threshold,
  input  wire logic [8-1:0]             summation_check_enable,
  input  wire logic [8*DLY_W-1:0]       alarm_delay_ms,
  // Static settings
  input  wire logic [1:0]               residual_source_select,
  input  wire logic                     residual_polarity_select,
  input  wire logic                     residual_monitor_enable,
  input  wire logic                     compensate_cmd,
  // Control
  input  wire logic                     block_in,
  input  wire logic                     counter_reset,
  // Outputs
  output logic                          alarm,
  output logic                          blocked,
  output logic [CNT_W-1:0]              alarm_count,
  output logic [CNT_W-1:0]              blocked_count,
  // Event stream
  output logic                          event_valid,
  output logic [1:0]                    event_code,
  output logic [TS_W-1:0]               event_time,
  // Pre-fault history
  output logic [W-1:0]                  prefault_a,
  output logic [W-1:0]                  prefault_b,
  output logic [W-1:0]                  prefault_c
);
  localparam int WR = W + `CTS_RATIO_FRAC + 8;

  // ****************************************
  // Group selection
  // ****************************************
  wire [W-1:0]     upper = phase_upper_threshold[group_select*W +: W];
  wire [W-1:0]     lower = phase_lower_threshold[group_select*W +: W];
  wire [7:0]       mmr   = min_max_ratio_threshold[group_select*8 +: 8];
  wire [7:0]       npr   = neg_pos_sequence_ratio_threshold[group_select*8 +: 8];
  wire [W-1:0]     sumth = summation_difference_threshold[group_select*W +: W];
  wire             sumen = summation_check_enable[group_select];
  wire [DLY_W-1:0] delay = alarm_delay_ms[group_select*DLY_W +: DLY_W];

  // Threshold scaled by percent; hysteresis is always relative to the setting
  function automatic logic [W+7:0] pct(input logic [W-1:0] v, input logic [7:0] p);
    logic [W+7:0] t;
    t = (W+8)'(v) * (W+8)'(p);
    return t / (W+8)'(`CTS_PCT_FULL);
  endfunction

  // Compare a > b * r / 2^frac without division
  function automatic logic ratio_gt(input logic [W-1:0] a, input logic [W-1:0] b,
                                    input logic [7:0] r);
    return (WR'(a) << `CTS_RATIO_FRAC) > WR'(b) * WR'(r);
  endfunction

  // Compare a < b * r / 2^frac; strict, so an equal ratio does not pick up
  function automatic logic ratio_lt(input logic [W-1:0] a, input logic [W-1:0] b,
                                    input logic [7:0] r);
    return (WR'(a) << `CTS_RATIO_FRAC) < WR'(b) * WR'(r);
  endfunction

  function automatic logic [W-1:0] max3(input logic [W-1:0] x, y, z);
    logic [W-1:0] m;
    m = (x > y) ? x : y;
    return (m > z) ? m : z;
  endfunction

  // ****************************************
  // Measurement latch
  // ****************************************
  logic [W-1:0] a_q, b_q, c_q, i1_q, i2_q, res_q, off_q;
  logic         upd_q;
  wire  [W-1:0] res_sel = (residual_source_select == `CTS_RES_ONE) ? residual_one_magnitude :
                          (residual_source_select == `CTS_RES_TWO) ? residual_two_magnitude :
                          '0;
  wire          res_on  = residual_monitor_enable &&
                          (residual_source_select != `CTS_RES_NONE);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      a_q   <= '0;
      b_q   <= '0;
      c_q   <= '0;
      i1_q  <= '0;
      i2_q  <= '0;
      res_q <= '0;
      upd_q <= 1'b0;
    end else begin
      upd_q <= meas_valid;
      if (meas_valid) begin
        a_q   <= phase_a_magnitude;
        b_q   <= phase_b_magnitude;
        c_q   <= phase_c_magnitude;
        i1_q  <= positive_sequence_current;
        i2_q  <= negative_sequence_current;
        res_q <= res_on ? res_sel : '0;
      end
    end
  end

  // ****************************************
  // Condition evaluation
  // ****************************************
  wire [W-1:0] pmax = max3(a_q, b_q, c_q);
  wire [W-1:0] pmin = ~max3(~a_q, ~b_q, ~c_q);
  logic cond_q;
  // Hysteresis: once picked up, limits relax to the release side
  wire [W+7:0] up_lim  = pct(upper, cond_q ? 8'(`CTS_HYST_HI_PCT) : 8'(`CTS_PCT_FULL));
  wire [W+7:0] lo_hi   = pct(lower, cond_q ? 8'(`CTS_HYST_LO_PCT) : 8'(`CTS_PCT_FULL));
  wire [W+7:0] lo_lo   = pct(lower, cond_q ? 8'(`CTS_HYST_HI_PCT) : 8'(`CTS_PCT_FULL));
  wire c_high  = ((W+8)'(pmax) <= up_lim);
  wire c_above = ((W+8)'(pmax) >  lo_hi);
  wire c_below = ((W+8)'(pmin) <  lo_lo);
  wire c_mm    = ratio_lt(pmin, pmax, mmr) || (pmax == '0);
  wire c_seq   = ratio_gt(i2_q, i1_q, npr);
  // Residual compensated, then signed by polarity
  wire [W-1:0]   res_c = (res_q > off_q) ? res_q - off_q : '0;
  wire [W+2:0]   psum  = (W+3)'(a_q) + (W+3)'(b_q) + (W+3)'(c_q);
  wire [W+2:0]   tsum  = residual_polarity_select ?
                         ((psum > (W+3)'(res_c)) ? psum - (W+3)'(res_c) : '0) :
                         psum + (W+3)'(res_c);
  wire c_sum   = !sumen || (tsum > (W+3)'(sumth));
  wire all_ok  = c_high && c_above && c_below && c_mm && c_seq && c_sum;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) off_q <= '0;
    else if (compensate_cmd && res_on) off_q <= res_q;
  end

  // ****************************************
  // Delay state machine
  // ****************************************
  logic              ms_tick;
  logic [TS_W-1:0]   ms_time;
  cts_state_t        st_q, st_d;
  logic [DLY_W-1:0]  tmr_q;
  wire               tmr_done = (tmr_q >= delay);

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      CTS_IDLE:  if (all_ok && !block_in) st_d = CTS_TIME;
      CTS_TIME:  if (!all_ok || block_in) st_d = CTS_IDLE;
                 else if (tmr_done) st_d = CTS_ALARM;
      CTS_ALARM: if (!all_ok || block_in) st_d = CTS_IDLE;
      default:   st_d = CTS_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q   <= CTS_IDLE;
      tmr_q  <= '0;
      cond_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      cond_q <= all_ok;
      if (st_d != CTS_TIME) tmr_q <= '0;
      else if (ms_tick && !tmr_done) tmr_q <= tmr_q + 1'b1;
    end
  end

  // ****************************************
  // Outputs, events and counters
  // ****************************************
  logic alarm_q, blk_q;
  logic [CNT_W-1:0] acnt_q, bcnt_q;
  logic ev_q;
  logic [1:0] evc_q;
  logic [TS_W-1:0] evt_q;
  wire alarm_d = (st_d == CTS_ALARM);
  wire blk_d   = block_in;
  wire a_chg   = alarm_d != alarm_q;
  wire b_chg   = blk_d != blk_q;
  // Pending block edge is kept when both change at once; it is dropped if block_in changes again in the next cycle
  logic bpend_q;
  logic bpval_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      alarm_q <= 1'b0;
      blk_q   <= 1'b0;
      ev_q    <= 1'b0;
      evc_q   <= `CTS_EV_ALARM_ON;
      evt_q   <= '0;
      acnt_q  <= '0;
      bcnt_q  <= '0;
      bpend_q <= 1'b0;
      bpval_q <= 1'b0;
    end else begin
      alarm_q <= alarm_d;
      blk_q   <= blk_d;
      ev_q    <= a_chg || b_chg || bpend_q;
      evt_q   <= ms_time;
      if (a_chg) begin
        evc_q   <= alarm_d ? `CTS_EV_ALARM_ON : `CTS_EV_ALARM_OFF;
        bpend_q <= b_chg;
        bpval_q <= blk_d;
      end else if (b_chg) begin
        evc_q   <= blk_d ? `CTS_EV_BLOCK_ON : `CTS_EV_BLOCK_OFF;
        bpend_q <= 1'b0;
      end else if (bpend_q) begin
        evc_q   <= bpval_q ? `CTS_EV_BLOCK_ON : `CTS_EV_BLOCK_OFF;
        bpend_q <= 1'b0;
      end
      // Reset wins only when no new on event for that counter arrives in the same cycle
      if (a_chg && alarm_d) acnt_q <= counter_reset ? CNT_W'(1) : acnt_q + 1'b1;
      else if (counter_reset) acnt_q <= '0;
      if (b_chg && blk_d) bcnt_q <= counter_reset ? CNT_W'(1) : bcnt_q + 1'b1;
      else if (counter_reset) bcnt_q <= '0;
    end
  end

  assign alarm         = alarm_q;
  assign blocked       = blk_q;
  assign alarm_count   = acnt_q;
  assign blocked_count = bcnt_q;
  assign event_valid   = ev_q;
  assign event_code    = evc_q;
  assign event_time    = evt_q;

  // ****************************************
  // Helpers
  // ****************************************
  cts_timestamp #(.TS_W(TS_W)) u_ts (
    .clk     (clk),
    .reset_n (reset_n),
    .ms_tick (ms_tick),
    .ms_time (ms_time)
  );

  wire capture = alarm_d && !alarm_q;
  cts_prefault #(.W(W)) u_pa (
    .clk      (clk),
    .reset_n  (reset_n),
    .sample   (upd_q),
    .value    (a_q),
    .capture  (capture),
    .prefault (prefault_a)
  );
  cts_prefault #(.W(W)) u_pb (
    .clk      (clk),
    .reset_n  (reset_n),
    .sample   (upd_q),
    .value    (b_q),
    .capture  (capture),
    .prefault (prefault_b)
  );
  cts_prefault #(.W(W)) u_pc (
    .clk      (clk),
    .reset_n  (reset_n),
    .sample   (upd_q),
    .value    (c_q),
    .capture  (capture),
    .prefault (prefault_c)
  );
endmodule
`default_nettype wire

// *** src/cts_defs.svh ***
// Constants for the current transformer supervision block.
// Assumes a 100 MHz clock and a 5 ms measurement update strobe.
`ifndef CTS_DEFS_SVH
`define CTS_DEFS_SVH
`define CTS_CLK_PERIOD_NS   10
`define CTS_MS_NS           1000000
`define CTS_MS_CYCLES       (`CTS_MS_NS / `CTS_CLK_PERIOD_NS)
`define CTS_NUM_GROUPS      8
`define CTS_PREFAULT_MS     20
`define CTS_PREFAULT_SHIFT  2
`define CTS_HYST_LO_PCT     97
`define CTS_HYST_HI_PCT     103
`define CTS_PCT_FULL        100
`define CTS_RATIO_FRAC      8
`define CTS_RES_NONE        2'h0
`define CTS_RES_ONE         2'h1
`define CTS_RES_TWO         2'h2
`define CTS_EV_ALARM_ON     2'h0
`define CTS_EV_ALARM_OFF    2'h1
`define CTS_EV_BLOCK_ON     2'h2
`define CTS_EV_BLOCK_OFF    2'h3
`endif

// *** src/cts_pkg.sv ***
// Types for the current transformer supervision block.
// Assumes cts_defs.svh is available on the include path.
package cts_pkg;
  typedef enum logic [2:0] {
    CTS_IDLE  = 3'b001,
    CTS_TIME  = 3'b010,
    CTS_ALARM = 3'b100
  } cts_state_t;
endpackage

// *** src/cts_timestamp.sv ***
// Millisecond time base for event stamps.
// Assumes the single 100 MHz clock.
`timescale 1ns/100ps
`default_nettype none
`include "cts_defs.svh"
module cts_timestamp
  import cts_pkg::*;
#(
  parameter int TS_W = 32
) (
  // Clock and reset
  input  wire logic            clk,
  input  wire logic            reset_n,
  // Time outputs
  output logic                 ms_tick,
  output logic [TS_W-1:0]      ms_time
);
  localparam int DIV_W = $clog2(`CTS_MS_CYCLES);
  logic [DIV_W-1:0] div_q;
  logic [TS_W-1:0]  time_q;
  wire              wrap = (div_q == DIV_W'(`CTS_MS_CYCLES - 1));

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      div_q  <= '0;
      time_q <= '0;
    end else begin
      div_q  <= wrap ? '0 : div_q + 1'b1;
      if (wrap) time_q <= time_q + 1'b1;
    end
  end

  assign ms_tick = wrap;
  assign ms_time = time_q;
endmodule
`default_nettype wire

// *** src/cts_prefault.sv ***
// Pre-fault history average of one magnitude channel.
// Assumes one sample strobe every 5 ms; 20 ms is four samples.
`timescale 1ns/100ps
`default_nettype none
`include "cts_defs.svh"
module cts_prefault
  import cts_pkg::*;
#(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         reset_n,
  // Samples
  input  wire logic         sample,
  input  wire logic [W-1:0] value,
  input  wire logic         capture,
  // Result
  output logic [W-1:0]      prefault
);
  localparam int DEPTH = 1 << `CTS_PREFAULT_SHIFT;
  logic [W-1:0] hist_q [0:2*DEPTH-1];
  logic [W+`CTS_PREFAULT_SHIFT-1:0] sum;
  logic [W-1:0] pre_q;

  // Oldest four samples cover the window ending 20 ms before the event
  always_comb begin
    sum = '0;
    for (int i = DEPTH; i < 2*DEPTH; i++) sum = sum + (W+`CTS_PREFAULT_SHIFT)'(hist_q[i]);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 2*DEPTH; i++) hist_q[i] <= '0;
      pre_q <= '0;
    end else begin
      if (sample) begin
        hist_q[0] <= value;
        for (int i = 1; i < 2*DEPTH; i++) hist_q[i] <= hist_q[i-1];
      end
      if (capture) pre_q <= sum[W+`CTS_PREFAULT_SHIFT-1:`CTS_PREFAULT_SHIFT];
    end
  end

  assign prefault = pre_q;
endmodule
`default_nettype wire

// *** sim/cts_supervision_props.sv ***
// Assertions on the ports of the supervision block.
// Assumes a bind from the bench with the design's width W.
`timescale 1ns/100ps
`default_nettype none
`include "cts_defs.svh"
module cts_supervision_props
  import cts_pkg::*;
#(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic           clk,
  input wire logic           reset_n,
  // Watched inputs
  input wire logic           meas_valid,
  input wire logic [W-1:0]   phase_a_magnitude,
  input wire logic [W-1:0]   phase_b_magnitude,
  input wire logic [W-1:0]   phase_c_magnitude,
  input wire logic [2:0]     group_select,
  input wire logic [8*W-1:0] phase_upper_threshold,
  input wire logic [8*W-1:0] phase_lower_threshold,
  input wire logic           block_in,
  // Watched outputs
  input wire logic           alarm,
  input wire logic           blocked,
  input wire logic           event_valid,
  input wire logic [1:0]     event_code
);
  logic [W-1:0] a_q, b_q, c_q, mx_w, mn_w;
  logic [31:0]  up_w, lo_w;
  logic         over_w, none_w, all_w;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      {a_q, b_q, c_q} <= '0;
    end else if (meas_valid) begin
      {a_q, b_q, c_q} <= {phase_a_magnitude, phase_b_magnitude, phase_c_magnitude};
    end
  end
  assign mx_w = (a_q > b_q) ? ((a_q > c_q) ? a_q : c_q) : ((b_q > c_q) ? b_q : c_q);
  assign mn_w = (a_q < b_q) ? ((a_q < c_q) ? a_q : c_q) : ((b_q < c_q) ? b_q : c_q);
  assign up_w = 32'(phase_upper_threshold[group_select*W +: W]);
  assign lo_w = 32'(phase_lower_threshold[group_select*W +: W]);
  // Outside both hysteresis edges, so release bands never fire these
  assign over_w = 32'(mx_w) * `CTS_PCT_FULL > up_w * `CTS_HYST_HI_PCT;
  assign none_w = 32'(mx_w) * `CTS_PCT_FULL < lo_w * `CTS_HYST_LO_PCT;
  assign all_w  = 32'(mn_w) * `CTS_PCT_FULL > lo_w * `CTS_HYST_HI_PCT;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_blk_on; block_in |=> blocked; endproperty
  a_blk_on: assert property (p_blk_on) else $error("blocked late");
  property p_blk_off; !block_in |=> !blocked; endproperty
  a_blk_off: assert property (p_blk_off) else $error("blocked stuck");
  property p_blk_alarm; block_in[*3] |-> !alarm; endproperty
  a_blk_alarm: assert property (p_blk_alarm) else $error("alarm while blocked");
  property p_upper; over_w[*3] |-> !alarm; endproperty
  a_upper: assert property (p_upper) else $error("alarm above upper");
  property p_none; none_w[*3] |-> !alarm; endproperty
  a_none: assert property (p_none) else $error("alarm all low");
  property p_all; all_w ##1 all_w ##1 all_w |-> !alarm; endproperty
  a_all: assert property (p_all) else $error("alarm all high");
  property p_ev_on; $rose(alarm) |-> ##[0:2] (event_valid && event_code == `CTS_EV_ALARM_ON);
  endproperty
  a_ev_on: assert property (p_ev_on) else $error("no alarm on event");
  property p_ev_off; $fell(alarm) |-> ##[0:2] (event_valid && event_code == `CTS_EV_ALARM_OFF);
  endproperty
  a_ev_off: assert property (p_ev_off) else $error("no alarm off event");
  property p_ev_blk; $rose(blocked) |-> ##[0:2] (event_valid && event_code == `CTS_EV_BLOCK_ON);
  endproperty
  a_ev_blk: assert property (p_ev_blk) else $error("no block event");
endmodule
`default_nettype wire

// *** sim/cts_meas_model.sv ***
// Model of the measurement stage feeding the block.
// Assumes the bench sets requested values; they go out on each update.
`timescale 1ns/100ps
`default_nettype none
module cts_meas_model #(
  parameter int W   = 16,
  parameter int PER = 40
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               reset_n,
  // Requested values
  input  wire logic [11:0][W-1:0] req,
  // Measurement stream
  output logic                    meas_valid,
  output logic [11:0][W-1:0]      meas
);
  // Period shortened from 5 ms to keep the run brief
  logic [15:0] cnt_q;
  logic        tick_w;
  assign tick_w = (cnt_q == 16'(PER - 1));
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q      <= 16'h0000;
      meas_valid <= 1'b0;
      meas       <= '0;
    end else begin
      cnt_q      <= tick_w ? 16'h0000 : cnt_q + 16'h0001;
      meas_valid <= tick_w;
      if (tick_w) begin
        meas <= req;
      end
    end
  end
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
// Self-checking bench for the supervision block.
// Assumes the model and checker files are compiled before it.
`timescale 1ns/100ps
`default_nettype none
`include "cts_defs.svh"
module tb_top;
  localparam int W = 16;
  typedef logic [6:0][W-1:0] cts_vec_t;
  localparam cts_vec_t NORM = {16'h0000,16'h01f4,16'h0,16'h0,16'h01f4,16'h01f4,16'h01f4};
  localparam cts_vec_t OPEN = {16'h012c,16'h0190,16'h0,16'h00c8,16'h0,16'h01f4,16'h01f4};
  localparam cts_vec_t BAD [5] = '{
    {16'h012c,16'h0190,16'h0,16'h00c8,16'h0,16'h01f4,16'h07d0},
    {16'h012c,16'h0190,16'h0,16'h00c8,16'h0,16'h0032,16'h0032},
    {16'h012c,16'h0190,16'h0,16'h00c8,16'h00c8,16'h01f4,16'h01f4},
    {16'h012c,16'h0190,16'h0,16'h00c8,16'h005a,16'h006e,16'h006e},
    {16'h0032,16'h0190,16'h0,16'h00c8,16'h0,16'h01f4,16'h01f4}};
  logic               clk = 1'b0, reset_n = 1'b0;
  logic [11:0][W-1:0] req = '0, meas;
  logic               meas_valid, alarm, blocked, ev_valid;
  logic [2:0]         grp = 3'h0;
  logic [1:0]         src = 2'h0, ev_code;
  logic               pol = 1'b0, blk = 1'b0, crst = 1'b0, comp = 1'b0, rmon = 1'b1;
  logic [8*W-1:0]     up_thr = {{4{16'h03e8}}, 16'h0190, {3{16'h03e8}}};
  logic [8*W-1:0]     lo_thr = {8{16'h0064}}, sum_thr = {8{16'h044c}}, dly = '0;
  logic [15:0]        a_cnt, b_cnt;
  logic [31:0]        ev_time;
  logic [W-1:0]       pf_a, pf_b, pf_c;
  logic [1:0]         evq [$];
  int error_cnt = 0, checks = 0, seed = 15, cyc = 0, exp_a = 0, exp_b = 0;
  always #5 clk = ~clk;
  cts_meas_model #(.W(W), .PER(40)) u_meas (.clk(clk), .reset_n(reset_n), .req(req),
    .meas_valid(meas_valid), .meas(meas));
  cts_supervision u_dut (.clk(clk), .reset_n(reset_n), .meas_valid(meas_valid),
    .phase_a_magnitude(meas[0]), .phase_b_magnitude(meas[1]), .phase_c_magnitude(meas[2]),
    .residual_one_magnitude(meas[3]), .residual_two_magnitude(meas[4]),
    .positive_sequence_current(meas[5]), .negative_sequence_current(meas[6]),
    .phase_a_angle(meas[7]), .phase_b_angle(meas[8]), .phase_c_angle(meas[9]),
    .residual_one_angle(meas[10]), .residual_two_angle(meas[11]), .group_select(grp),
    .phase_upper_threshold(up_thr), .phase_lower_threshold(lo_thr),
    .min_max_ratio_threshold({8{8'h80}}), .neg_pos_sequence_ratio_threshold({8{8'h40}}),
    .summation_difference_threshold(sum_thr), .summation_check_enable(8'h80),
    .alarm_delay_ms(dly), .residual_source_select(src), .residual_polarity_select(pol),
    .residual_monitor_enable(rmon), .compensate_cmd(comp), .block_in(blk),
    .counter_reset(crst), .alarm(alarm), .blocked(blocked), .alarm_count(a_cnt),
    .blocked_count(b_cnt), .event_valid(ev_valid), .event_code(ev_code),
    .event_time(ev_time), .prefault_a(pf_a), .prefault_b(pf_b), .prefault_c(pf_c));
  task automatic cmp_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic cmp_ev(input logic [1:0] exp, input logic [1:0] got);
    cmp_val("event_code", {30'h0, exp}, {30'h0, got});
  endtask
  task automatic summarize();
    $display("Checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic expect_ev(input logic [1:0] code);
    evq.push_back(code);
    exp_a += (code == `CTS_EV_ALARM_ON);
    exp_b += (code == `CTS_EV_BLOCK_ON);
  endtask
  // New values wait for the next update, then settle
  task automatic step(input cts_vec_t v);
    @(posedge clk);
    req[6:0] <= v;
    for (int i = 7; i < 12; i++) req[i] <= W'($random(seed));
    repeat (80) @(posedge clk);
  endtask
  task automatic trial(input logic ok, input cts_vec_t v);
    if (ok) expect_ev(`CTS_EV_ALARM_ON);
    step(v);
    cmp_val("alarm", {31'h0, ok}, {31'h0, alarm});
    if (ok) expect_ev(`CTS_EV_ALARM_OFF);
    step(NORM);
  endtask
  function automatic logic [W-1:0] rnd();
    return 16'h012c + W'($unsigned($random(seed)) % 100);
  endfunction
  always @(posedge clk) begin
    if (reset_n === 1'b1 && ev_valid === 1'b1) begin
      cmp_ev((evq.size() > 0) ? evq.pop_front() : ~ev_code, ev_code);
      cmp_val("event_time", 32'h0, ev_time);
    end
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      $display("Error timeout expected done seen running");
      summarize();
    end
  end
  initial begin
    req[6:0] = NORM;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    step(NORM);
    for (int g = 0; g < 8; g++) begin
      @(posedge clk);
      grp <= g[2:0];
      trial(g != 3 && g != 7, OPEN);
    end
    $display("Test groups done");
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      src  <= (i == 4) ? `CTS_RES_ONE : 2'((i + 1) / 2);
      pol  <= (i == 2);
      rmon <= (i != 4);
      trial(i == 1, OPEN);
    end
    @(posedge clk);
    src  <= `CTS_RES_ONE;
    rmon <= 1'b1;
    expect_ev(`CTS_EV_ALARM_ON);
    step(OPEN);
    expect_ev(`CTS_EV_ALARM_OFF);
    comp <= 1'b1;
    @(posedge clk);
    comp <= 1'b0;
    step(OPEN);
    cmp_val("alarm", 32'h0, {31'h0, alarm});
    step(NORM);
    $display("Test summation done");
    grp <= 3'h0;
    for (int i = 0; i < 5; i++) trial(1'b0, BAD[i]);
    for (int i = 0; i < 3; i++) trial(1'b0, {OPEN[6:3], rnd(), rnd(), rnd()});
    $display("Test conditions done");
    // Long normal run so the whole history window holds balanced load
    repeat (3) step(NORM);
    expect_ev(`CTS_EV_ALARM_ON);
    step(OPEN);
    cmp_val("prefault_a", 32'h1f4, {16'h0, pf_a});
    cmp_val("prefault_b", 32'h1f4, {16'h0, pf_b});
    cmp_val("prefault_c", 32'h1f4, {16'h0, pf_c});
    expect_ev(`CTS_EV_ALARM_OFF);
    expect_ev(`CTS_EV_BLOCK_ON);
    blk <= 1'b1;
    step(OPEN);
    cmp_val("alarm", 32'h0, {31'h0, alarm});
    cmp_val("blocked", 32'h1, {31'h0, blocked});
    step(NORM);
    expect_ev(`CTS_EV_BLOCK_OFF);
    blk <= 1'b0;
    step(NORM);
    cmp_val("blocked", 32'h0, {31'h0, blocked});
    $display("Test block done");
    cmp_val("alarm_count", 32'(exp_a), {16'h0, a_cnt});
    cmp_val("blocked_count", 32'(exp_b), {16'h0, b_cnt});
    crst <= 1'b1;
    repeat (3) @(posedge clk);
    crst <= 1'b0;
    @(posedge clk);
    cmp_val("alarm_count", 32'h0, {16'h0, a_cnt});
    cmp_val("blocked_count", 32'h0, {16'h0, b_cnt});
    cmp_val("event_queue", 32'h0, 32'(evq.size()));
    $display("Test counters done");
    summarize();
  end
endmodule
bind cts_supervision cts_supervision_props #(.W(W)) u_props (.clk(clk), .reset_n(reset_n),
  .meas_valid(meas_valid), .phase_a_magnitude(phase_a_magnitude),
  .phase_b_magnitude(phase_b_magnitude), .phase_c_magnitude(phase_c_magnitude),
  .group_select(group_select), .phase_upper_threshold(phase_upper_threshold),
  .phase_lower_threshold(phase_lower_threshold), .block_in(block_in), .alarm(alarm),
  .blocked(blocked), .event_valid(event_valid), .event_code(event_code));
`default_nettype wire
